// [dbc_defines.svh]
// Timing counts, field positions and reset values for the DRAM board cycle controller.
// Assumes a single 50 MHz clock; all cycle counts derive from the ns values below.
//
// Functional notes
// - Extended address bits must match jumper value.
// - Select needs five terms, taken at delayed sync.
// - Mid address offset by start; range match selects.
// - Translated address compared against size jumpers.
// - Arbitrate refresh and select latches, pick cycle type.
// - Cycle flags valid at 50ns; chain ends 250ns.
// - Cycle end clears only the serviced latch.
// - Normal cycle strobes one row at 50ns.
// - Refresh strobes both rows from 150ns.
// - Row address idle, column at 100ns.
// - Column strobe at 150ns, normal cycles only.
// - Read reply asserted at 200ns.
// - Write enables need 150ns and data-out strobe.
// - Word write both bytes; byte write by bit0.
// - Refresh uses counter address; counter then increments.
// - One parity bit per data byte on write.
// - Bit 16 on write forces wrong parity.
// - Read parity mismatch raises bus/jumper error.
// - No cycles while power-good is low.
// - Refresh from oscillator, or bus refresh by jumper.
// - Transceivers drive bus only during read.
// - Either reply drives bus reply.
// - Reply drops after strobe; master then drops sync.
// - One refresh about every 16 microseconds.
// - I/O page signal deselects when jumper fitted.
`ifndef DBC_DEFINES_SVH
`define DBC_DEFINES_SVH
`define DBC_CLK_MHZ        50
`define DBC_T_FLAG_NS      50
`define DBC_T_MUX_NS       100
`define DBC_T_CAS_NS       150
`define DBC_T_RPLY_NS      200
`define DBC_T_END_NS       250
`define DBC_T_REF_NS       16000
`define DBC_CYC_UP(ns)     (((ns) * `DBC_CLK_MHZ + 999) / 1000)
`define DBC_T_FLAG_CYC     `DBC_CYC_UP(`DBC_T_FLAG_NS)
`define DBC_T_MUX_CYC      `DBC_CYC_UP(`DBC_T_MUX_NS)
`define DBC_T_CAS_CYC      `DBC_CYC_UP(`DBC_T_CAS_NS)
`define DBC_T_RPLY_CYC     `DBC_CYC_UP(`DBC_T_RPLY_NS)
`define DBC_T_END_CYC      `DBC_CYC_UP(`DBC_T_END_NS)
`define DBC_T_REF_CYC      ((`DBC_T_REF_NS * `DBC_CLK_MHZ) / 1000)
`define DBC_ROW_LSB        1
`define DBC_COL_LSB        9
`define DBC_MID_LSB        11
`define DBC_FPAR_BIT       16
`define DBC_CNT_RST        8'h00
`endif

// [dbc_pkg.sv]
// Types shared by the DRAM board cycle controller.
// Assumes the defines header is compiled alongside.
package dbc_pkg;
   typedef enum logic [1:0] {DBC_IDLE, DBC_RUN, DBC_DONE} dbc_state_t;
   // Bus control pins, as seen after the receivers (levels as on the pins)
   typedef struct packed {
      logic sync_n;
      logic din_n;
      logic dout_n;
      logic wtbt_n;
      logic bs7_n;
      logic bref_n;
      logic dcok;
   } dbc_pins_t;
   // Static board straps
   typedef struct packed {
      logic [3:0] ext_match;
      logic [6:0] start;
      logic [6:0] size;
      logic       bs7_dsel_en;
      logic       row_sel;
      logic       parity_fit;
      logic       bus_ref_sel;
      logic       perr_jmp_en;
   } dbc_jumpers_t;
endpackage : dbc_pkg

// [dbc_ctrl.sv]
// DRAM board cycle controller: select, arbitration, cycle timing, strobes,
// write enables, replies, refresh and parity.
// Assumes bus pins and straps are asynchronous to i_clk; memory read data is
// settled by the reply tap.
//
// The implementer's own choices: the plain strobed port and the register offsets.
`include "dbc_defines.svh"
module dbc_ctrl #(
   parameter int DAL_W = 22,
   parameter int MA_W  = 8
) (
   input  wire logic               i_clk,
   input  wire logic               i_resetn,
   input  wire dbc_pkg::dbc_pins_t    i_pins,
   input  wire dbc_pkg::dbc_jumpers_t i_jumpers,
   input  wire logic [DAL_W-1:0]   i_dal,
   input  wire logic [17:0]        i_mem_rdata,
   output logic [15:0]             o_dal_out,
   output logic                    o_dal_oe,
   output logic                    o_bus_perr,
   output logic                    o_perr_jumper,
   output logic                    o_rply_n,
   output logic                    o_row_strobe_bank0_n,
   output logic                    o_row_strobe_bank1_n,
   output logic                    o_col_strobe_n,
   output logic [MA_W-1:0]         o_dram_address_lines,
   output logic                    o_write_enable_low_byte_n,
   output logic                    o_write_enable_high_byte_n,
   output logic [17:0]             o_mem_wdata,
   output logic                    o_normal_cycle_flag,
   output logic                    o_refresh_cycle_flag
);
   import dbc_pkg::*;

   initial begin
      if (DAL_W != 22 || MA_W != 8) begin
         $error("dbc_ctrl: only DAL_W=22, MA_W=8 supported");
      end
   end

   localparam logic [7:0] T_FLAG = 8'(`DBC_T_FLAG_CYC);
   localparam logic [7:0] T_MUX  = 8'(`DBC_T_MUX_CYC);
   localparam logic [7:0] T_CAS  = 8'(`DBC_T_CAS_CYC);
   localparam logic [7:0] T_RPLY = 8'(`DBC_T_RPLY_CYC);
   localparam logic [7:0] T_END  = 8'(`DBC_T_END_CYC);
   localparam logic [9:0] T_REF  = 10'(`DBC_T_REF_CYC);

   // Odd parity bit for one byte
   function automatic logic odd_par(input logic [7:0] b);
      odd_par = ~^b;
   endfunction : odd_par

   // Pin synchronisers; first stage read only by second
   dbc_pins_t          pins_m_r, pins_s_r;
   dbc_jumpers_t       jmp_m_r, jmp_s_r;
   logic [DAL_W-1:0]   dal_m_r, dal_s_r;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pins_m_r <= '{sync_n:1'b1, din_n:1'b1, dout_n:1'b1, wtbt_n:1'b1,
                       bs7_n:1'b1, bref_n:1'b1, dcok:1'b0};
         pins_s_r <= '{sync_n:1'b1, din_n:1'b1, dout_n:1'b1, wtbt_n:1'b1,
                       bs7_n:1'b1, bref_n:1'b1, dcok:1'b0};
         jmp_m_r  <= '0;
         jmp_s_r  <= '0;
         dal_m_r  <= '0;
         dal_s_r  <= '0;
      end else begin
         pins_m_r <= i_pins;
         pins_s_r <= pins_m_r;
         jmp_m_r  <= i_jumpers;
         jmp_s_r  <= jmp_m_r;
         dal_m_r  <= i_dal;
         dal_s_r  <= dal_m_r;
      end
   end

   logic sync_act, din_act, dout_act, wtbt_act;
   assign sync_act = !pins_s_r.sync_n;
   assign din_act  = !pins_s_r.din_n;
   assign dout_act = !pins_s_r.dout_n;
   assign wtbt_act = !pins_s_r.wtbt_n;

   // Sync edge and the delayed sync used to take the select decision
   logic sync_prev_r, delayed_sync_r;
   logic sync_fall;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         sync_prev_r    <= 1'b0;
         delayed_sync_r <= 1'b0;
      end else begin
         sync_prev_r    <= sync_act;
         delayed_sync_r <= sync_fall;
      end
   end
   assign sync_fall = sync_act && !sync_prev_r;

   // Address portion captured at sync; read/write decided there too
   logic [DAL_W-1:0] addr_r;
   logic             is_write_r;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         addr_r     <= '0;
         is_write_r <= 1'b0;
      end else if (sync_fall) begin
         addr_r     <= dal_s_r;
         is_write_r <= wtbt_act;
      end
   end

   // Select terms
   logic [3:0] extended_address_bits;
   logic [6:0] latched_address_mid_bits;
   logic [7:0] translated_address;
   logic       ext_ok, range_ok, size_ok, bs7_ok, board_sel;
   logic       latched_byte_select, address_bit_sixteen;
   assign extended_address_bits    = addr_r[21:18];
   assign latched_address_mid_bits = addr_r[17:`DBC_MID_LSB];
   assign latched_byte_select      = addr_r[0];
   assign address_bit_sixteen      = dal_s_r[`DBC_FPAR_BIT];
   assign ext_ok = (extended_address_bits == jmp_s_r.ext_match);
   // start offset adder; no borrow means in range
   assign translated_address = {1'b0, latched_address_mid_bits} - {1'b0, jmp_s_r.start};
   assign range_ok = !translated_address[7];
   assign size_ok  = (translated_address[6:0] < jmp_s_r.size);
   assign bs7_ok   = !(!pins_s_r.bs7_n && jmp_s_r.bs7_dsel_en);
   // five terms, power good among them
   assign board_sel = ext_ok && range_ok && size_ok && bs7_ok && pins_s_r.dcok;

   // Refresh source: internal oscillator or bus refresh
   logic [9:0] osc_cnt_r;
   logic       bref_prev_r;
   logic       osc_tick, bref_fall, ref_tick;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         osc_cnt_r   <= '0;
         bref_prev_r <= 1'b0;
      end else begin
         osc_cnt_r   <= osc_tick ? '0 : osc_cnt_r + 10'h001;
         bref_prev_r <= !pins_s_r.bref_n;
      end
   end
   assign osc_tick  = (osc_cnt_r == T_REF - 10'h001);
   assign bref_fall = !pins_s_r.bref_n && !bref_prev_r;
   assign ref_tick  = jmp_s_r.bus_ref_sel ? bref_fall : osc_tick;

   // Request latches and the cycle sequencer
   dbc_state_t state_r;
   logic [7:0] cnt_r;
   logic       ref_req_r, sel_req_r, refresh_r;
   logic       start, cyc_end;
   logic       ref_clr, sel_clr;
   // arbitration; refresh wins a tie, no start without power good
   assign start   = (state_r == DBC_IDLE) && (ref_req_r || sel_req_r) && pins_s_r.dcok;
   // chain ends at the last tap; normal waits for sync release
   assign cyc_end = (state_r == DBC_DONE) && (refresh_r || !sync_act);
   assign ref_clr = cyc_end && refresh_r;
   assign sel_clr = cyc_end && !refresh_r;

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ref_req_r <= 1'b0;
      end else if (ref_tick) begin
         ref_req_r <= 1'b1;
      end else if (ref_clr) begin
         ref_req_r <= 1'b0;
      end
   end
   // request stays latched across a refresh
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         sel_req_r <= 1'b0;
      end else if (delayed_sync_r && board_sel) begin
         sel_req_r <= 1'b1;
      end else if (sel_clr) begin
         sel_req_r <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_r   <= DBC_IDLE;
         cnt_r     <= `DBC_CNT_RST;
         refresh_r <= 1'b0;
      end else begin
         case (state_r)
            DBC_IDLE: begin
               cnt_r <= `DBC_CNT_RST;
               if (start) begin
                  state_r   <= DBC_RUN;
                  refresh_r <= ref_req_r;
               end
            end
            DBC_RUN: begin
               cnt_r <= cnt_r + 8'h01;
               if (cnt_r == T_END - 8'h01) begin
                  state_r <= DBC_DONE;
               end
            end
            DBC_DONE: begin
               if (cyc_end) begin
                  state_r <= DBC_IDLE;
               end
            end
            default: state_r <= DBC_IDLE;
         endcase
      end
   end
   logic active, past_flag, past_mux, past_cas, past_rply, normal, refr;
   assign active    = (state_r != DBC_IDLE);
   assign past_flag = active && (cnt_r >= T_FLAG);
   assign past_mux  = active && (cnt_r >= T_MUX);
   assign past_cas  = active && (cnt_r >= T_CAS);
   assign past_rply = active && (cnt_r >= T_RPLY);
   assign normal    = past_flag && !refresh_r;
   assign refr      = past_flag && refresh_r;

   // cycle type flags only from the first tap
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_normal_cycle_flag  <= 1'b0;
         o_refresh_cycle_flag <= 1'b0;
      end else begin
         o_normal_cycle_flag  <= normal;
         o_refresh_cycle_flag <= refr;
      end
   end

   // Row and column strobes
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_row_strobe_bank0_n <= 1'b1;
         o_row_strobe_bank1_n <= 1'b1;
         o_col_strobe_n       <= 1'b1;
      end else begin
         // one row for normal; both rows for refresh
         o_row_strobe_bank0_n <= !((normal && !jmp_s_r.row_sel) || (refr && past_cas));
         o_row_strobe_bank1_n <= !((normal && jmp_s_r.row_sel) || (refr && past_cas));
         o_col_strobe_n       <= !(past_cas && !refresh_r);
      end
   end

   // Address multiplexer and refresh counter
   logic [MA_W-1:0] ref_addr_r;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ref_addr_r <= '0;
      end else if (ref_clr) begin
         ref_addr_r <= ref_addr_r + 8'h01;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_dram_address_lines <= '0;
      end else if (refr) begin
         o_dram_address_lines <= ref_addr_r;
      end else if (past_mux && !refresh_r) begin
         o_dram_address_lines <= addr_r[`DBC_COL_LSB +: MA_W];
      end else begin
         o_dram_address_lines <= addr_r[`DBC_ROW_LSB +: MA_W];
      end
   end

   // Write enables and write data with parity
   logic wr_ok, byte_wr, wr_lo, wr_hi;
   // needs the cas tap and data-out strobe
   assign wr_ok   = past_cas && !refresh_r && is_write_r && dout_act;
   assign byte_wr = wtbt_act;
   // word writes both; byte by bit0
   assign wr_lo   = wr_ok && (!byte_wr || !latched_byte_select);
   assign wr_hi   = wr_ok && (!byte_wr || latched_byte_select);
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_write_enable_low_byte_n  <= 1'b1;
         o_write_enable_high_byte_n <= 1'b1;
      end else begin
         o_write_enable_low_byte_n  <= !wr_lo;
         o_write_enable_high_byte_n <= !wr_hi;
      end
   end

   logic force_bad;
   assign force_bad = jmp_s_r.parity_fit && address_bit_sixteen;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_mem_wdata <= '0;
      end else begin
         o_mem_wdata <= {odd_par(dal_s_r[15:8]) ^ force_bad,
                         odd_par(dal_s_r[7:0]) ^ force_bad,
                         dal_s_r[15:0]};
      end
   end

   // Replies, read data and parity check
   logic rd_rply_r, rd_go, par_err;
   assign rd_go   = past_rply && !refresh_r && !is_write_r && din_act;
   // recompute over data and stored bit
   assign par_err = jmp_s_r.parity_fit &&
                    (!(^{i_mem_rdata[7:0], i_mem_rdata[16]}) ||
                     !(^{i_mem_rdata[15:8], i_mem_rdata[17]}));
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rd_rply_r <= 1'b0;
      end else begin
         // read reply at 200ns, held while data-in
         rd_rply_r <= rd_go;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rply_n <= 1'b1;
      end else begin
         o_rply_n <= !(rd_go || wr_ok);
      end
   end
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_dal_out     <= '0;
         o_dal_oe      <= 1'b0;
         o_bus_perr    <= 1'b0;
         o_perr_jumper <= 1'b0;
      end else begin
         o_dal_oe <= rd_go;
         if (rd_go && !rd_rply_r) begin
            o_dal_out     <= i_mem_rdata[15:0];
            // error to bus and strap output
            o_bus_perr    <= par_err;
            o_perr_jumper <= par_err && jmp_s_r.perr_jmp_en;
         end else if (!rd_go) begin
            o_bus_perr    <= 1'b0;
            o_perr_jumper <= 1'b0;
         end
      end
   end
   // Checks
   logic [8:0] wait_cnt_r;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         wait_cnt_r <= '0;
      end else if (!sel_req_r || active && !refresh_r) begin
         wait_cnt_r <= '0;
      end else begin
         wait_cnt_r <= wait_cnt_r + 9'h001;
      end
   end

   chk_flag_timing: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (o_normal_cycle_flag || o_refresh_cycle_flag) |-> $past(cnt_r) >= T_FLAG)
      else $error("cycle flag before first tap");
   chk_row_one_bank: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_normal_cycle_flag |-> (o_row_strobe_bank0_n != o_row_strobe_bank1_n))
      else $error("normal cycle strobed other than one row");
   chk_refresh_rows: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (refr && cnt_r == T_CAS) |=> (!o_row_strobe_bank0_n && !o_row_strobe_bank1_n))
      else $error("refresh did not strobe both rows");
   chk_cas_normal: assert property (@(posedge i_clk) disable iff (!i_resetn)
      !o_col_strobe_n |-> $past(active && !refresh_r && cnt_r >= T_CAS))
      else $error("column strobe outside normal cycle");
   chk_read_reply: assert property (@(posedge i_clk) disable iff (!i_resetn)
      $fell(o_rply_n) && !is_write_r |-> $past(cnt_r) >= T_RPLY)
      else $error("read reply too early");
   chk_we_gate: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (!o_write_enable_low_byte_n || !o_write_enable_high_byte_n)
      |-> $past(dout_act && cnt_r >= T_CAS))
      else $error("write enable without strobe or time");
   chk_byte_write: assert property (@(posedge i_clk) disable iff (!i_resetn)
      $past(wr_ok && byte_wr) |-> (o_write_enable_low_byte_n != o_write_enable_high_byte_n))
      else $error("byte write enabled both bytes");
   chk_no_power: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (state_r == DBC_IDLE && !pins_s_r.dcok) |=> state_r == DBC_IDLE)
      else $error("cycle started without power good");
   chk_bus_drive: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_dal_oe |-> !is_write_r && !refresh_r)
      else $error("bus driven outside read");
   chk_refresh_step: assert property (@(posedge i_clk) disable iff (!i_resetn)
      ref_clr |=> ref_addr_r == $past(ref_addr_r) + 8'h01)
      else $error("refresh counter did not advance");
   chk_sel_latency: assert property (@(posedge i_clk) disable iff (!i_resetn)
      wait_cnt_r < 9'(T_END) + 9'h008)
      else $error("bus request waited beyond one cycle");
   chk_read_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (!o_rply_n && !is_write_r && din_act) |=> !o_rply_n)
      else $error("read reply dropped while data-in held");

endmodule : dbc_ctrl

// [dbc_master.sv]
// Bus master model: drives sync, strobes and the multiplexed address/data lines.
// Assumes the controller answers on o_rply_n; every wait here is bounded.
module dbc_master (
   input  wire logic          i_clk,
   input  wire logic          i_rply_n,
   input  wire logic [17:0]   i_rdata,
   output dbc_pkg::dbc_pins_t o_pins,
   output logic [21:0]        o_dal
);
   import dbc_pkg::*;
   initial begin
      o_pins = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
      o_dal  = 22'h2aaaaa;
   end
   task automatic cycle(input logic wr, input logic bw, input logic bs7,
                        input logic [21:0] a, input logic [16:0] wd,
                        output logic got, output logic [17:0] rd);
      int n;
      got = 1'b0;
      rd  = 18'h00000;
      @(posedge i_clk);
      o_pins.sync_n <= 1'b0;
      o_pins.wtbt_n <= ~wr;
      o_pins.bs7_n  <= ~bs7;
      o_dal         <= a;
      repeat (3) @(posedge i_clk);
      o_pins.bs7_n  <= 1'b1;
      o_pins.wtbt_n <= ~(wr & bw);
      o_dal         <= wr ? {5'h00, wd} : ~a;
      if (wr) o_pins.dout_n <= 1'b0;
      else o_pins.din_n <= 1'b0;
      for (n = 0; n < 80 && !got; n++) begin
         @(posedge i_clk);
         if (i_rply_n === 1'b0) begin
            got = 1'b1;
            rd  = i_rdata;
         end
      end
      // strobe off, reply off, then sync off
      o_pins.din_n  <= 1'b1;
      o_pins.dout_n <= 1'b1;
      for (n = 0; n < 20 && i_rply_n !== 1'b1; n++) @(posedge i_clk);
      // Reply stuck low counts as no reply
      if (i_rply_n !== 1'b1) got = 1'b0;
      o_pins.sync_n <= 1'b1;
      o_pins.wtbt_n <= 1'b1;
      o_dal         <= ~o_dal;
      repeat (6) @(posedge i_clk);
   endtask : cycle
   task automatic set_dcok(input logic v);
      @(posedge i_clk);
      o_pins.dcok <= v;
   endtask : set_dcok
   task automatic pulse_bref;
      @(posedge i_clk);
      o_pins.bref_n <= 1'b0;
      repeat (4) @(posedge i_clk);
      o_pins.bref_n <= 1'b1;
      repeat (40) @(posedge i_clk);
   endtask : pulse_bref
endmodule : dbc_master

// [dbc_ctrl_test.sv]
// Self-checking bench for the board cycle controller with a small memory model.
// Assumes dbc_master as bus partner; refresh tick of 800 clocks.
module dbc_ctrl_test;
   timeunit 1ns;
   timeprecision 1ns;
   import dbc_pkg::*;
   logic i_clk = 1'b0, i_resetn = 1'b0, dal_oe, perr, perr_j, rply_n;
   logic rs0_n, rs1_n, cs_n, wel_n, weh_n, ncy, rcy, got, b0, b1, both_q;
   dbc_pins_t    pins;
   dbc_jumpers_t jmp;
   logic [21:0]  dal, cur, a;
   logic [17:0]  mem_rdata, wdata, rd, mem [0:63];
   logic [15:0]  dal_out, w, d;
   logic [7:0]   ma, last_ref;
   int           num_errors = 0, checks = 0, nref = 0, seed = 62, i, n;
   always #10 i_clk = ~i_clk;
   dbc_master u_master (.i_clk(i_clk), .i_rply_n(rply_n), .i_rdata({perr_j, perr, dal_out}),
      .o_pins(pins), .o_dal(dal));
   dbc_ctrl u_dbc_ctrl (.i_clk(i_clk), .i_resetn(i_resetn), .i_pins(pins), .i_jumpers(jmp),
      .i_dal(dal), .i_mem_rdata(mem_rdata), .o_dal_out(dal_out), .o_dal_oe(dal_oe),
      .o_bus_perr(perr), .o_perr_jumper(perr_j), .o_rply_n(rply_n),
      .o_row_strobe_bank0_n(rs0_n), .o_row_strobe_bank1_n(rs1_n), .o_col_strobe_n(cs_n),
      .o_dram_address_lines(ma), .o_write_enable_low_byte_n(wel_n),
      .o_write_enable_high_byte_n(weh_n), .o_mem_wdata(wdata), .o_normal_cycle_flag(ncy),
      .o_refresh_cycle_flag(rcy));
   task automatic chk(input logic [17:0] g, input logic [17:0] e, input string what);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %0t %s got %h exp %h", $time, what, g, e);
      end
   endtask : chk
   task automatic wrap_up;
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : wrap_up
   // Odd parity per byte, inverted when forced
   function automatic logic [17:0] word(input logic [15:0] v, input logic bad);
      return {~^v[15:8] ^ bad, ~^v[7:0] ^ bad, v};
   endfunction : word
   task automatic op(input logic wr, input logic bw, input logic bs7, input logic [21:0] ad,
                     input logic [16:0] wd);
      cur = ad;
      b0  = 1'b0;
      b1  = 1'b0;
      u_master.cycle(wr, bw, bs7, ad, wd, got, rd);
   endtask : op
   task automatic wr_rd(input logic [21:0] ad, input logic [16:0] wd, input logic bw,
                        input logic [17:0] e);
      op(1'b1, bw, 1'b0, ad, wd);
      chk(got, 1'b1, "write reply");
      if (!bw) chk(mem[ad[6:1]], word(wd[15:0], wd[16]), "stored parity");
      op(1'b0, 1'b0, 1'b0, ad, 17'h00000);
      chk(got, 1'b1, "read reply");
      chk(rd, e, "read data");
      chk({b0, b1}, {~jmp.row_sel, jmp.row_sel}, "row bank");
   endtask : wr_rd
   task automatic none(input logic bs7, input logic [21:0] ad);
      op(1'b0, 1'b0, bs7, ad, 17'h00000);
      chk(got, 1'b0, "unselected reply");
   endtask : none
   always @(posedge i_clk) begin
      mem_rdata <= mem[cur[6:1]];
      if (wel_n === 1'b0) {mem[cur[6:1]][16], mem[cur[6:1]][7:0]} <= {wdata[16], wdata[7:0]};
      if (weh_n === 1'b0) {mem[cur[6:1]][17], mem[cur[6:1]][15:8]} <= {wdata[17], wdata[15:8]};
      if (ncy === 1'b1) {b0, b1} = {b0 | ~rs0_n, b1 | ~rs1_n};
      if (cs_n === 1'b0) chk(ma, cur[16:9], "column address");
      if (rcy === 1'b1 && {rs0_n, rs1_n} === 2'b00 && !both_q) begin
         if (nref > 0) chk(ma, 8'(last_ref + 8'h01), "refresh address");
         nref++;
         last_ref = ma;
      end
      both_q = (rcy === 1'b1 && {rs0_n, rs1_n} === 2'b00);
      if (dal_oe === 1'b1 && {wel_n, weh_n} !== 2'b11) chk(1'b1, 1'b0, "drive in write");
   end
   initial begin
      repeat (60000) @(posedge i_clk);
      num_errors++;
      wrap_up();
   end
   initial begin
      jmp = '{4'h5, 7'h02, 7'h04, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
      {cur, both_q, b0, b1, last_ref} = '0;
      repeat (16) @(posedge i_clk);
      i_resetn <= 1'b1;
      repeat (2) @(posedge i_clk);
      for (i = 0; i < 16; i++) begin
         a = {4'h5, 7'h02 + 7'($unsigned($random(seed)) % 4), 11'($random(seed))};
         w = 16'($random(seed));
         jmp.row_sel <= (i >= 8);
         wr_rd(a, {1'b0, w}, 1'b0, {2'b00, w});
      end
      wr_rd({4'h5, 7'h05, 11'h7fe}, 17'h0a5c3, 1'b0, 18'h0a5c3);
      wr_rd({4'h5, 7'h02, 11'h000}, 17'h05a3c, 1'b0, 18'h05a3c);
      none(1'b0, {4'h5, 7'h06, 11'h010});
      none(1'b0, {4'h5, 7'h01, 11'h010});
      none(1'b0, {4'h6, 7'h03, 11'h010});
      w = 16'($random(seed));
      d = 16'($random(seed));
      wr_rd(22'h1418a4, {1'b0, w}, 1'b0, {2'b00, w});
      wr_rd(22'h1418a4, {1'b0, d}, 1'b1, {2'b00, w[15:8], d[7:0]});
      wr_rd(22'h1418a5, {1'b0, w}, 1'b1, {2'b00, w[15:8], d[7:0]});
      wr_rd(22'h1418a8, {1'b1, d}, 1'b0, {2'b11, d});
      jmp.perr_jmp_en <= 1'b0;
      op(1'b0, 1'b0, 1'b0, 22'h1418a8, 17'h00000);
      chk(rd, {2'b01, d}, "parity error pins");
      none(1'b1, 22'h1418a8);
      jmp.bs7_dsel_en <= 1'b0;
      op(1'b0, 1'b0, 1'b1, 22'h1418a8, 17'h00000);
      chk(got, 1'b1, "block 7 reply");
      u_master.set_dcok(1'b0);
      repeat (40) @(posedge i_clk);
      n = nref;
      repeat (1700) @(posedge i_clk);
      none(1'b0, 22'h1418a8);
      chk(nref - n, 0, "refresh while power low");
      u_master.set_dcok(1'b1);
      jmp.bus_ref_sel <= 1'b1;
      repeat (40) @(posedge i_clk);
      n = nref;
      repeat (1700) @(posedge i_clk);
      chk(nref - n, 0, "oscillator cut off");
      u_master.pulse_bref();
      u_master.pulse_bref();
      chk(nref - n, 2, "bus refresh count");
      jmp.bus_ref_sel <= 1'b0;
      repeat (40) @(posedge i_clk);
      n = nref;
      repeat (4000) @(posedge i_clk);
      chk(nref - n inside {[4:5]}, 1'b1, "refresh rate");
      wrap_up();
   end
endmodule : dbc_ctrl_test
